// >>> design/ttp_top.sv
// Time-of-day capture/load control with carrier symbol encoder and decoder.
// Accumulator value arrives on tod_now; loads leave as a pulse with a value.
`timescale 1ns/10ps
module ttp_top
  import ttp_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int PW    = 16
)(
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Accumulator side
  input  wire logic [87:0] tod_now,
  input  wire logic        pps_int,
  input  wire logic        pps_alt,
  output logic             tod_load,
  output logic      [87:0] tod_load_val,
  output logic             tod_trig,
  // Pins
  input  wire logic        sync_pulse,
  input  wire logic        gpio_in,
  output logic             gpio_out,
  input  wire logic        carrier_in,
  output logic             carrier_out,
  input  wire logic        rx_carrier
);
  import ttp_pkg::*;

  // Elaboration checks: FIFO pointers are four bits, period counter must span 8 kHz
  if (DEPTH < 2 || DEPTH > 16) $error("DEPTH out of range");
  if (PW < $clog2(MAX_PER_CYC) + 1) $error("PW too narrow for slowest carrier");

  typedef struct packed {
    logic [7:0]              ctrl, trig, gcfg, enc_id, dec_id, tx_dst, rdata;
    logic [15:0]             sig;
    logic                    perr;
    logic [31:0]             tmr;
    logic                    tmr_run;
    logic [87:0]             stage, snap, gtime;
    logic [DEPTH-1:0][87:0]  fifo;
    logic [3:0]              wp, rp;
    logic [4:0]              cnt;
    logic                    ecap_arm, eload_arm;
    logic [2:0]              cs, rs, ss, gs, ps, as;
    logic [PW-1:0]           pcnt, per, ph;
    logic                    cout;
    logic [1:0]              sym;
    ttp_enc_t                est;
    logic [111:0]            tsh;
    logic [6:0]              left;
    logic                    reply;
    logic [PW-1:0]           rcnt, rper, rhi;
    logic [111:0]            rsh;
    logic [6:0]              rn;
    logic                    ract;
    logic                    ld;
    logic [87:0]             ldv;
    logic                    trg, gout;
  } ttp_state_t;

  ttp_state_t s_q, s_d;

  // Frame image: header, time payload, even parity bit last
  function automatic logic [111:0] mk_frame(logic [7:0] src, logic bc, logic [7:0] dst,
                                            logic [87:0] t);
    logic [110:0] body;
    body = {CMD_PPS, 3'b000, src, bc, dst, t};
    return {body, ^body};
  endfunction

  function automatic logic [87:0] put_byte(logic [87:0] v, logic [7:0] i, logic [7:0] b);
    logic [87:0] r;
    r = v;
    for (int k = 0; k < TBYTES; k++)
      if (i == 8'(k)) r[k*8 +: 8] = b;
    return r;
  endfunction

  function automatic logic [7:0] get_byte(logic [87:0] v, logic [7:0] i);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < TBYTES; k++)
      if (i == 8'(k)) r = v[k*8 +: 8];
    return r;
  endfunction

  logic        cap_req;
  logic [87:0] cap_val;
  logic        c_rise, r_rise, r_fall, sp_rise, g_rise, pps_rise;
  logic [7:0]  off;
  logic [1:0]  nsym;
  logic [PW-1:0] thr;
  logic [PW+2:0] hi8, per3, per5;
  logic [1:0]  rsym;
  logic [111:0] rfr;

  // Next state
  always_comb
  begin
    s_d = s_q;
    cap_req = 1'b0;
    cap_val = tod_now;
    off = 8'h00;
    nsym = SYM_SPACE;
    thr = '0;
    hi8 = '0;
    per3 = '0;
    per5 = '0;
    rsym = SYM_SPACE;
    rfr = s_q.rsh;
    s_d.ld = 1'b0;
    s_d.trg = 1'b0;
    // Two-stage synchronisers; the third bit only remembers the previous level
    s_d.cs = {s_q.cs[1:0], carrier_in};
    s_d.rs = {s_q.rs[1:0], rx_carrier};
    s_d.ss = {s_q.ss[1:0], sync_pulse};
    s_d.gs = {s_q.gs[1:0], gpio_in};
    s_d.ps = {s_q.ps[1:0], pps_int};
    s_d.as = {s_q.as[1:0], pps_alt};
    c_rise = s_q.cs[1] & ~s_q.cs[2];
    r_rise = s_q.rs[1] & ~s_q.rs[2];
    r_fall = ~s_q.rs[1] & s_q.rs[2];
    sp_rise = s_q.ss[1] & ~s_q.ss[2];
    g_rise = s_q.gs[1] & ~s_q.gs[2];
    pps_rise = s_q.ctrl[C_PPS_ALT] ? (s_q.as[1] & ~s_q.as[2]) : (s_q.ps[1] & ~s_q.ps[2]);

    // Register writes
    if (wr)
    begin
      case (addr)
        A_CTRL:   s_d.ctrl = wdata;
        A_TRIG:   s_d.trig = wdata;
        A_GCFG:   s_d.gcfg = wdata;
        A_SIG_HI: s_d.sig[15:8] = wdata;
        A_SIG_LO: s_d.sig[7:0] = wdata;
        A_ENC_ID: s_d.enc_id = wdata;
        A_DEC_ID: s_d.dec_id = wdata;
        A_TX_DST: s_d.tx_dst = wdata;
        default:  ;
      endcase
      if (addr >= A_TMR0 && addr <= A_TMR3)
        s_d.tmr[(addr - A_TMR0) * 8 +: 8] = wdata;
      if (addr == A_TMR3)
        s_d.tmr_run = 1'b1;
      if (addr == A_STATUS && wdata[0])
        s_d.perr = 1'b0;
      if (addr >= A_STAGE0 && addr < A_STAGE0 + 8'(TBYTES))
        s_d.stage = put_byte(s_q.stage, addr - A_STAGE0, wdata);
      if (addr >= A_GTIME0 && addr < A_GTIME0 + 8'(TBYTES))
        s_d.gtime = put_byte(s_q.gtime, addr - A_GTIME0, wdata);
      // Completing the seconds MSB hands the staged value over
      if (addr == A_STAGE0 + 8'(TBYTES - 1))
      begin
        s_d.ld = 1'b1;
        s_d.ldv = put_byte(s_q.stage, addr - A_STAGE0, wdata);
      end
      if (addr == A_CTRL)
      begin
        s_d.ecap_arm = wdata[C_ECAP];
        s_d.eload_arm = wdata[C_ELOAD];
      end
    end

    // Register reads, answered one cycle later
    if (rd)
    begin
      case (addr)
        A_CTRL:   s_d.rdata = s_q.ctrl;
        A_TRIG:   s_d.rdata = s_q.trig;
        A_GCFG:   s_d.rdata = s_q.gcfg;
        A_SIG_HI: s_d.rdata = s_q.sig[15:8];
        A_SIG_LO: s_d.rdata = s_q.sig[7:0];
        A_ENC_ID: s_d.rdata = s_q.enc_id;
        A_DEC_ID: s_d.rdata = s_q.dec_id;
        A_TX_DST: s_d.rdata = s_q.tx_dst;
        A_STATUS: s_d.rdata = {s_q.gout, s_q.tmr_run, s_q.est != TTP_IDLE, s_q.cnt};
        default:  s_d.rdata = 8'h00;
      endcase
      if (addr == A_STATUS)
        s_d.rdata[7] = s_q.perr;
      if (addr >= A_TMR0 && addr <= A_TMR3)
        s_d.rdata = s_q.tmr[(addr - A_TMR0) * 8 +: 8];
      if (addr >= A_SNAP0 && addr < A_SNAP0 + 8'(TBYTES))
        s_d.rdata = get_byte(s_q.snap, addr - A_SNAP0);
      if (addr >= A_STAGE0 && addr < A_STAGE0 + 8'(TBYTES))
        s_d.rdata = get_byte(s_q.stage, addr - A_STAGE0);
      if (addr >= A_GTIME0 && addr < A_GTIME0 + 8'(TBYTES))
        s_d.rdata = get_byte(s_q.gtime, addr - A_GTIME0);
      if (addr >= A_FIFO0 && addr < A_FIFO0 + 8'(TBYTES))
        s_d.rdata = (s_q.cnt != 5'h00) ?
                    get_byte(s_q.fifo[s_q.rp[$clog2(DEPTH)-1:0]], addr - A_FIFO0) : 8'h00;
      // Pre-word read freezes the whole time so the byte reads agree
      if (addr == A_PREWORD)
        s_d.snap = tod_now;
    end

    // Capture sources, none with priority over another; simultaneous ones are merged
    if ((rd || wr) && addr == s_q.trig)
      cap_req = 1'b1;
    if (sp_rise && s_q.ecap_arm)
    begin
      cap_req = 1'b1;
      s_d.ecap_arm = s_q.ctrl[C_ECAP_CONT];
    end
    // GPIO only ever captures, never loads
    if (g_rise && s_q.gcfg[G_IN])
    begin
      if (s_q.gcfg[G_TO_FIFO])
        cap_req = 1'b1;
      else
        s_d.gtime = tod_now;
    end
    if (s_q.tmr_run)
    begin
      if (s_q.tmr <= 32'(TMR_DEC))
      begin
        s_d.tmr = 32'h0000_0000;
        s_d.tmr_run = 1'b0;
        s_d.trg = 1'b1;
        cap_req = 1'b1;
      end
      else
        s_d.tmr = s_q.tmr - 32'(TMR_DEC);
    end
    if (cap_req && s_q.cnt != 5'(DEPTH))
    begin
      s_d.fifo[s_q.wp[$clog2(DEPTH)-1:0]] = cap_val;
      s_d.wp = (s_q.wp == 4'(DEPTH - 1)) ? 4'h0 : s_q.wp + 4'h1;
    end
    // Reading the last FIFO byte retires the entry
    if (rd && addr == A_FIFO0 + 8'(TBYTES - 1) && s_q.cnt != 5'h00)
      s_d.rp = (s_q.rp == 4'(DEPTH - 1)) ? 4'h0 : s_q.rp + 4'h1;
    s_d.cnt = s_q.cnt + 5'(s_d.wp != s_q.wp) - 5'(s_d.rp != s_q.rp);

    // Sync pulse may also load
    if (sp_rise && s_q.eload_arm)
    begin
      s_d.ld = 1'b1;
      s_d.ldv = s_q.stage;
      s_d.eload_arm = s_q.ctrl[C_ELOAD_CONT];
    end

    // GPIO trigger output is high while the accumulator is at or past the mark
    s_d.gout = s_q.gcfg[G_OUT] && (tod_now >= s_q.gtime);

    // Encoder start: signature or pps frame after a 1PPS edge
    if (s_q.est == TTP_IDLE)
    begin
      if (pps_rise && s_q.ctrl[C_SIG])
      begin
        s_d.est = TTP_SIG;
        s_d.tsh = {s_q.sig, 96'h0};
        s_d.left = 7'(SIG_SYMS);
      end
      else if ((pps_rise && !s_q.ctrl[C_SIG]) || s_q.reply)
      begin
        s_d.est = TTP_FRAME;
        s_d.tsh = mk_frame(s_q.enc_id, s_q.gcfg[G_BCAST], s_q.tx_dst, tod_now);
        s_d.left = 7'(FRAME_BITS);
        s_d.reply = 1'b0;
      end
    end

    // Carrier regeneration: rise follows the input, only the fall moves
    s_d.pcnt = s_q.pcnt + 1'b1;
    s_d.ph = s_q.ph + 1'b1;
    if (c_rise)
    begin
      case (s_q.est)
        TTP_SIG:   nsym = s_q.tsh[111:110];
        TTP_FRAME: nsym = s_q.tsh[111] ? SYM_ONE : SYM_ZERO;
        default:   nsym = SYM_SPACE;
      endcase
      if (s_q.est != TTP_IDLE)
      begin
        s_d.tsh = (s_q.est == TTP_SIG) ? {s_q.tsh[109:0], 2'b00} : {s_q.tsh[110:0], 1'b0};
        s_d.left = s_q.left - 7'h01;
        if (s_q.left == 7'h01)
          s_d.est = TTP_IDLE;
      end
      s_d.per = s_q.pcnt + 1'b1;
      s_d.pcnt = '0;
      s_d.ph = '0;
      s_d.cout = 1'b1;
      s_d.sym = nsym;
    end
    else
    begin
      case (s_q.sym)
        SYM_ZERO: thr = s_q.per >> 2;
        SYM_ONE:  thr = s_q.per - (s_q.per >> 2);
        default:  thr = s_q.per >> 1;
      endcase
      if (s_q.ph + 1'b1 >= thr)
        s_d.cout = 1'b0;
    end

    // Decoder: measure period and high time, classify at each rise
    s_d.rcnt = s_q.rcnt + 1'b1;
    if (r_fall)
      s_d.rhi = s_q.rcnt;
    if (r_rise)
    begin
      s_d.rper = s_q.rcnt;
      s_d.rcnt = '0;
      hi8 = {s_q.rhi, 3'b000};
      per3 = (PW+3)'(s_q.rcnt) * (PW+3)'(3);
      per5 = (PW+3)'(s_q.rcnt) * (PW+3)'(5);
      if (hi8 < per3)
        rsym = SYM_ZERO;
      else if (hi8 > per5)
        rsym = SYM_ONE;
      else
        rsym = SYM_SPACE;
      if (rsym == SYM_SPACE)
      begin
        s_d.ract = 1'b0;
        s_d.rn = 7'h00;
      end
      else
      begin
        rfr = {s_q.rsh[110:0], rsym == SYM_ONE};
        s_d.rsh = rfr;
        s_d.ract = 1'b1;
        s_d.rn = s_q.rn + 7'h01;
        if (s_q.rn == 7'(FRAME_BITS - 1))
        begin
          s_d.rn = 7'h00;
          if (^rfr)
            s_d.perr = 1'b1;
          else if (rfr[111:109] == CMD_PPS &&
                   (rfr[97] || rfr[96:89] == s_q.dec_id))
          begin
            if (rfr[88:1] == 88'h0)
            begin
              if (s_q.ctrl[C_REPLY])
                s_d.reply = 1'b1;
            end
            else if (s_q.ctrl[C_FLOAD])
            begin
              s_d.ld = 1'b1;
              s_d.ldv = rfr[88:1];
            end
          end
        end
      end
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.sig <= SIG_RST;
      s_q.est <= TTP_IDLE;
    end
    else if (ce)
      s_q <= s_d;
  end

  assign rdata        = s_q.rdata;
  assign tod_load     = s_q.ld;
  assign tod_load_val = s_q.ldv;
  assign tod_trig     = s_q.trg;
  assign gpio_out     = s_q.gout;
  assign carrier_out  = s_q.cout;
endmodule

// >>> design/ttp_pkg.sv
// Constants for the time-of-day capture/load block with its carrier encoder and decoder.
// Assumes one 40 MHz system clock; the time accumulator itself lives outside.
package ttp_pkg;
  // Register offsets (byte registers)
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_TRIG     = 8'h01;
  localparam logic [7:0] A_GCFG     = 8'h02;
  localparam logic [7:0] A_SIG_HI   = 8'h03;
  localparam logic [7:0] A_SIG_LO   = 8'h04;
  localparam logic [7:0] A_ENC_ID   = 8'h05;
  localparam logic [7:0] A_DEC_ID   = 8'h06;
  localparam logic [7:0] A_TX_DST   = 8'h07;
  localparam logic [7:0] A_STATUS   = 8'h08;
  localparam logic [7:0] A_TMR0     = 8'h09;
  localparam logic [7:0] A_TMR3     = 8'h0c;
  localparam logic [7:0] A_PREWORD  = 8'h0f;
  localparam logic [7:0] A_SNAP0    = 8'h10;
  localparam logic [7:0] A_STAGE0   = 8'h20;
  localparam logic [7:0] A_FIFO0    = 8'h30;
  localparam logic [7:0] A_GTIME0   = 8'h40;
  localparam int         TBYTES     = 11;
  localparam int         TBITS      = 88;
  // Control bits
  localparam int C_ECAP = 0;
  localparam int C_ECAP_CONT = 1;
  localparam int C_ELOAD = 2;
  localparam int C_ELOAD_CONT = 3;
  localparam int C_FLOAD = 4;
  localparam int C_REPLY = 5;
  localparam int C_SIG = 6;
  localparam int C_PPS_ALT = 7;
  // GPIO config bits
  localparam int G_IN = 0;
  localparam int G_OUT = 1;
  localparam int G_TO_FIFO = 2;
  localparam int G_BCAST = 3;
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] SIG_RST  = 16'h4000;
  // Symbols and commands
  localparam logic [1:0] SYM_SPACE = 2'h0;
  localparam logic [1:0] SYM_ZERO  = 2'h1;
  localparam logic [1:0] SYM_ONE   = 2'h2;
  localparam logic [2:0] CMD_PPS   = 3'h0;
  localparam logic [2:0] CMD_READ  = 3'h2;
  localparam logic [2:0] CMD_SYNC  = 3'h3;
  localparam int FRAME_BITS = 112;
  localparam int SIG_SYMS   = 8;
  // Timing
  localparam longint SYS_HZ         = 40_000_000;
  localparam longint SYS_PS         = 25_000;
  localparam longint TMR_STEP_PS    = 2_500;
  localparam longint TMR_DEC        = SYS_PS / TMR_STEP_PS;
  localparam longint CARRIER_MIN_HZ = 8_000;
  localparam longint CARRIER_MAX_HZ = 25_000_000;
  localparam longint MAX_PER_CYC    = SYS_HZ / CARRIER_MIN_HZ;
  // Encoder states
  typedef enum logic [1:0] {
    TTP_IDLE  = 2'b00,
    TTP_SIG   = 2'b01,
    TTP_FRAME = 2'b10
  } ttp_enc_t;
endpackage

// >>> verif/ttp_chk_asserts.sv
// Checker for ttp_top: load and trigger pulses, snapshot reads, carrier edges.
// Bound to ttp_top below; sees its ports only, one clock domain.
`timescale 1ns/10ps
module ttp_chk
  import ttp_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Register port
  input wire logic        ce,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  // Accumulator side
  input wire logic [87:0] tod_now,
  input wire logic        tod_load,
  input wire logic [87:0] tod_load_val,
  input wire logic        tod_trig,
  // Carrier
  input wire logic        carrier_in,
  input wire logic        carrier_out
);
  logic [7:0] now_lo;

  // Low byte of the accumulator, kept apart so it can be looked back at
  assign now_lo = tod_now[7:0];

  // Single domain: clock and reset stated once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_load_after_msb: assert property (ce && wr && addr == 8'h2A |=> tod_load)
    else $error("no load pulse after seconds MSB write");
  a_load_msb_val: assert property (
    ce && wr && addr == 8'h2A |=> tod_load_val[87:80] == $past(wdata))
    else $error("load value lacks the byte just written");
  a_load_pulse: assert property (tod_load |=> !tod_load)
    else $error("load pulse longer than one cycle");
  a_trig_pulse: assert property (tod_trig |=> !tod_trig)
    else $error("timer trigger longer than one cycle");
  a_preword_read: assert property (ce && rd && addr == 8'h0F |=> rdata == 8'h00)
    else $error("pre-word read not zero");
  a_snap_first: assert property (
    (ce && rd && addr == 8'h0F) ##1 (ce && rd && addr == 8'h10) |=> rdata == $past(now_lo, 2))
    else $error("snapshot byte differs from accumulator at pre-word read");
  // Rising edge of the output only ever follows the incoming carrier
  a_rise_follows: assert property ($rose(carrier_out) |-> $past(carrier_in, 2))
    else $error("carrier output rose without carrier input");
  a_fall_bound: assert property ($rose(carrier_out) |-> ##[1:7] !carrier_out)
    else $error("carrier output did not fall within one period");
endmodule

bind ttp_top ttp_chk u_chk (.sys_clk, .resetn, .ce, .addr, .wdata, .wr, .rd, .rdata,
  .tod_now, .tod_load, .tod_load_val, .tod_trig, .carrier_in, .carrier_out);

// >>> verif/ttp_far_end.sv
// Behavioural far-end timing device: makes the 200 ns carrier, sends one
// frame on the return carrier when asked, decodes symbols of the outgoing one.
`timescale 1ns/10ps
module ttp_far_end (
  // Carrier lines
  output logic             carrier,
  output logic             rx_line,
  input  wire logic        tx_line,
  // Frame to send, its strobe, and the frame decoded
  input  wire logic [111:0] tx_frame,
  input  wire logic        send,
  output logic [111:0]     got,
  output int               got_n
);
  int      idx = 112;
  realtime t_up;
  realtime h;

  initial
  begin
    carrier = 1'b0;
    rx_line = 1'b0;
    got = '0;
    got_n = 0;
  end

  // Free-running carrier; its rising edges never move
  always #100 carrier = ~carrier;

  // A new request restarts the frame; one made during a frame symbol skips bit 111
  always @(posedge send) idx = 0;

  // Falling edge carries the symbol: 50 ns zero, 150 ns one, 100 ns space
  always @(posedge carrier)
  begin
    rx_line = 1'b1;
    if (idx < 112)
    begin
      #(tx_frame[111 - idx] ? 150 : 50);
      idx++;
    end
    else
      #100;
    rx_line = 1'b0;
  end

  // Classify by high time; a space drops a partial frame, a full one is kept
  always @(posedge tx_line) t_up = $realtime;
  always @(negedge tx_line)
  begin
    h = $realtime - t_up;
    // A space after a full frame also rearms the count; the bits stay in got
    if (h < 70 || h > 130)
    begin
      if (got_n < 112)
      begin
        got = {got[110:0], h > 130};
        got_n++;
      end
    end
    else
      got_n = 0;
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for ttp_top: registers, captures, loads, timer, GPIO,
// and frames both ways through the far-end model. Random data, seed fixed.
`timescale 1ns/10ps
module tb_top;
  import ttp_pkg::*;
  // Stimulus and observed values
  logic         sys_clk = 1'b0;
  logic         resetn, ce, wr, rd, pps_alt, send, hit;
  logic [7:0]   addr, wdata, rq, b8;
  logic [15:0]  sg;
  logic [87:0]  tod_now, v, lv, t1, s;
  logic [111:0] tx_frame;
  logic [31:0]  tm;
  logic [2:0]   pins;
  wire          sync_pulse, pps_int, gpio_in, tod_load, tod_trig, gpio_out;
  wire          carrier_in, carrier_out, rx_carrier;
  wire  [7:0]   rdata;
  wire  [87:0]  tod_load_val;
  wire  [111:0] got;
  int           got_n, n, e, fail_count = 0, check_count = 0, cyc = 0;

  assign {gpio_in, pps_int, sync_pulse} = pins;

  ttp_top dut (.sys_clk, .resetn, .ce, .addr, .wdata, .wr, .rd, .rdata, .tod_now, .pps_int,
    .pps_alt, .tod_load, .tod_load_val, .tod_trig, .sync_pulse, .gpio_in, .gpio_out,
    .carrier_in, .carrier_out, .rx_carrier);
  ttp_far_end far (.carrier(carrier_in), .rx_line(rx_carrier), .tx_line(carrier_out),
    .tx_frame, .send, .got, .got_n);

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Hang guard; the run needs a few thousand cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Counts: mismatches %0d of %0d checks", fail_count, check_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [111:0] g, input logic [111:0] x, input string m);
    check_count++;
    if (g !== x)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask

  // One bus cycle; rq gets the data of the read issued by the previous call
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(negedge sys_clk) rq = rdata;
    @(posedge sys_clk);
  endtask

  task automatic reg1(input logic w, input logic [7:0] a, input logic [7:0] d);
    bus(w, !w, a, d);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  // Eleven back-to-back writes, subns byte first, seconds MSB last
  task automatic wr_t(input logic [7:0] a, input logic [87:0] x);
    for (int i = 0; i < 11; i++)
      bus(1'b1, 1'b0, a + 8'(i), x[8*i+:8]);
    // Strobe drops at the edge that takes the last write, so a load pulse is still ahead
    wr <= 1'b0;
  endtask

  // Eleven back-to-back reads into v
  task automatic rd_t(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    for (int i = 1; i < 12; i++)
    begin
      bus(1'b0, i < 11, a + 8'(i), 8'h00);
      v[8*(i-1)+:8] = rq;
    end
  endtask

  // Watch k cycles for a load pulse; the first one seen is kept in lv
  task automatic wait_load(input int k);
    hit = 1'b0;
    repeat (k)
    begin
      @(negedge sys_clk);
      if (tod_load === 1'b1 && !hit)
      begin
        hit = 1'b1;
        lv = tod_load_val;
      end
    end
    @(posedge sys_clk);
  endtask

  // Hold a pin high long enough for the synchronisers, watching for loads
  task automatic pulse(input int k);
    pins[k] <= 1'b1;
    wait_load(10);
    pins <= 3'b000;
    @(posedge sys_clk);
  endtask

  function automatic logic [87:0] r88();
    logic [95:0] t;
    t = {$urandom(), $urandom(), $urandom()};
    return t[87:0];
  endfunction

  // Expected frame: header, payload, even parity (optionally spoiled)
  function automatic logic [111:0] mk(logic [7:0] src, logic b, logic [7:0] dst,
                                      logic [87:0] p, logic bad);
    logic [111:0] x;
    x = {CMD_PPS, 3'b000, src, b, dst, p, 1'b0};
    x[0] = ^x[111:1] ^ bad;
    return x;
  endfunction

  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    pps_alt = 1'b0;
    send = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    tod_now = '0;
    pins = 3'b000;
    tx_frame = '0;
    void'($urandom(37));
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    // Reset values
    reg1(1'b0, A_CTRL, 8'h00);
    chk(rq, CTRL_RST, "ctrl reset");
    reg1(1'b0, A_SIG_HI, 8'h00);
    chk(rq, SIG_RST[15:8], "sig hi reset");
    reg1(1'b0, A_SIG_LO, 8'h00);
    chk(rq, SIG_RST[7:0], "sig lo reset");
    // Trigger address resets to CTRL, so the CTRL read above queued a capture
    rd_t(A_FIFO0);
    chk(v, 88'h0, "reset trigger capture");
    // Pre-word read freezes the time; a later accumulator change must not show
    t1 = r88();
    tod_now <= t1;
    bus(1'b0, 1'b1, A_PREWORD, 8'h00);
    tod_now <= r88();
    rd_t(A_SNAP0);
    chk(v, t1, "snapshot read");
    // Access to the chosen register captures; unmapped read gives zero
    reg1(1'b1, A_TRIG, A_TX_DST);
    t1 = r88();
    tod_now <= t1;
    reg1(1'b1, A_TX_DST, 8'h33);
    rd_t(A_FIFO0);
    chk(v, t1, "register access capture");
    reg1(1'b1, A_TRIG, 8'hEE);
    reg1(1'b0, 8'hFF, 8'h00);
    chk(rq, 8'h00, "unmapped read");
    // Sync pulse capture, once mode disarms
    reg1(1'b1, A_CTRL, 8'h01);
    t1 = r88();
    tod_now <= t1;
    pulse(0);
    rd_t(A_FIFO0);
    chk(v, t1, "sync capture");
    tod_now <= r88();
    pulse(0);
    reg1(1'b0, A_STATUS, 8'h00);
    chk(rq[4:0], 5'd0, "second edge ignored");
    // Staged write loads, then the same value loads on a sync edge
    reg1(1'b1, A_CTRL, 8'h04);
    s = r88();
    wr_t(A_STAGE0, s);
    wait_load(3);
    chk({hit, lv}, {1'b1, s}, "register load");
    pulse(0);
    chk({hit, lv}, {1'b1, s}, "sync edge load");
    // 1PPS and GPIO never load; 1PPS frame carries the captured time
    reg1(1'b1, A_CTRL, 8'h0C);
    reg1(1'b1, A_ENC_ID, 8'h5A);
    reg1(1'b1, A_TX_DST, 8'h33);
    reg1(1'b1, A_GCFG, 8'h09);
    t1 = r88();
    tod_now <= t1;
    pulse(1);
    chk(hit, 1'b0, "pps loaded");
    pulse(2);
    chk(hit, 1'b0, "gpio loaded");
    rd_t(A_GTIME0);
    chk(v, t1, "gpio capture");
    n = 0;
    while (got_n != 112 && n < 2000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(got, mk(8'h5A, 1'b1, 8'h33, t1, 1'b0), "sent frame");
    // Signature of random zeros and ones after a 1PPS edge, then silence
    b8 = 8'($urandom());
    for (int i = 0; i < 8; i++)
      sg[15-2*i -: 2] = b8[7-i] ? SYM_ONE : SYM_ZERO;
    reg1(1'b1, A_SIG_HI, sg[15:8]);
    reg1(1'b1, A_SIG_LO, sg[7:0]);
    reg1(1'b1, A_CTRL, 8'h40);
    pulse(1);
    repeat (160) @(posedge sys_clk);
    chk(got[7:0], b8, "signature symbols");
    chk(got_n, 0, "frame sent in signature mode");
    // GPIO output compare
    reg1(1'b1, A_GCFG, 8'h02);
    s = r88();
    wr_t(A_GTIME0, s);
    tod_now <= s - 88'd1;
    repeat (6) @(negedge sys_clk);
    chk(gpio_out, 1'b0, "gpio early");
    @(posedge sys_clk);
    tod_now <= s;
    repeat (6) @(negedge sys_clk);
    chk(gpio_out, 1'b1, "gpio at time");
    @(posedge sys_clk);
    // Countdown timer in 2.5 ns steps
    tm = 32'd100 + 32'($urandom_range(300));
    for (int i = 0; i < 4; i++)
      bus(1'b1, 1'b0, A_TMR0 + 8'(i), tm[8*i+:8]);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    e = int'(tm) / int'(TMR_DEC);
    n = 0;
    while (tod_trig !== 1'b1 && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= e - 2 && n <= e + 2, 1'b1, "timer expiry");
    @(posedge sys_clk);
    // Received frame loads; a parity error drops it and is flagged
    reg1(1'b1, A_CTRL, 8'h10);
    s = r88();
    tx_frame <= mk(8'h11, 1'b0, 8'h00, s, 1'b0);
    send <= 1'b1;
    wait_load(1200);
    chk({hit, lv}, {1'b1, s}, "frame load");
    send <= 1'b0;
    tx_frame <= mk(8'h11, 1'b0, 8'h00, r88(), 1'b1);
    @(posedge sys_clk);
    send <= 1'b1;
    wait_load(1200);
    chk(hit, 1'b0, "bad parity loaded");
    reg1(1'b0, A_STATUS, 8'h00);
    chk(rq[7], 1'b1, "parity flag");
    wrap_up();
  end
endmodule
